// file: design/core_power_map.vh
// constants for the core power mode controller
`ifndef CORE_POWER_MAP_VH
`define CORE_POWER_MAP_VH
`define ADDR_POWER_CONTROL 32'h0000_0000
`define ADDR_POWER_STATUS 32'h0000_0004
`define ADDR_WAKE_ENABLE 32'h0000_0008
`define ADDR_WATCHDOG_CTRL 32'h0000_000c
`define ADDR_CLOCK_DETECT_CTRL 32'h0000_0010
`define BIT_LIGHT_SLEEP 0
`define BIT_DEEP_HALT 1
`define WATCHDOG_RESET_VALUE 16'hffff
// 100 us detector timeout counted in 20 ns clock periods
`define CLOCK_DETECT_TIMEOUT_CYCLES 16'h1388
`define RESUME_VECTOR 16'h0000
`endif

// file: design/core_power_mode_control.v
// core low-power mode controller with ahb-lite register slave
//
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`include "core_power_map.vh"

// Contract
// R1: two low-power states, each by own bit
// R2: light sleep halts core, clocks keep running
// R3: deep halt stops core, timers, oscillator
// R4: light sleep begins after writing instruction completes
// R5: light sleep keeps registers and memory
// R6: enabled interrupt or reset ends light sleep
// R7: interrupt wake resumes after sleep instruction
// R8: reset wake restarts at address zero
// R9: enabled watchdog keeps counting, resets sleep
// R10: deep halt begins after writing instruction completes
// R11: only reset leaves deep halt
// R12: enabled clock detector resets out of halt
// R13: stopped oscillator needs reset to restart
// R14: select bits read zero, others reserved
// R15: both bits written selects deep halt
module core_power_mode_control (
  input wire clock,
  input wire reset,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire instr_complete,
  input wire [7:0] irq_request,
  input wire ext_clock_present,
  output reg core_halt_reg,
  output reg periph_clock_enable_reg,
  output reg int_osc_enable_reg,
  output reg system_reset_reg,
  output reg [15:0] reset_vector_reg,
  output reg wake_irq_pulse_reg
);

  localparam [1:0] st_run = 2'd0;
  localparam [1:0] st_pend_sleep = 2'd1;
  localparam [1:0] st_sleep = 2'd2;
  localparam [1:0] st_halt = 2'd3;

  localparam [15:0] clock_detect_init = `CLOCK_DETECT_TIMEOUT_CYCLES;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg pend_deep_reg;
  reg [7:0] wake_enable_reg;
  reg watchdog_enable_reg;
  reg watchdog_lock_reg;
  reg [15:0] watchdog_reload_reg;
  reg [15:0] watchdog_counter;
  reg clock_detect_enable_reg;
  reg [15:0] clock_detect_count_reg;
  reg [31:0] ap_addr_reg;
  reg ap_write_reg;
  reg ap_valid_reg;
  reg watchdog_fire_reg;
  reg clock_detect_fire_reg;
  wire [7:0] wake_masked;
  genvar i;

  wire addr_phase = hsel & hready & htrans[1];
  wire wr_phase = ap_valid_reg & ap_write_reg;

  // one gate per request line; a disabled line never wakes the core
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_wake
      assign wake_masked[i] = irq_request[i] & wake_enable_reg[i];
    end
  endgenerate

  wire wake_now = |wake_masked;

  function is_addr;
    input [31:0] a;
    input [31:0] b;
    begin
      is_addr = (a[7:2] == b[7:2]) && (a[31:8] == 24'h000000);
    end
  endfunction

  function is_deep;
    input [1:0] s;
    begin
      is_deep = (s == st_halt);
    end
  endfunction

  wire wr_power = wr_phase & is_addr(ap_addr_reg, `ADDR_POWER_CONTROL);
  wire set_sleep = wr_power & hwdata[`BIT_LIGHT_SLEEP];
  wire set_halt = wr_power & hwdata[`BIT_DEEP_HALT];
  wire wr_wake = wr_phase & is_addr(ap_addr_reg, `ADDR_WAKE_ENABLE);
  wire wr_watchdog = wr_phase & is_addr(ap_addr_reg, `ADDR_WATCHDOG_CTRL);
  wire wr_detect = wr_phase & is_addr(ap_addr_reg, `ADDR_CLOCK_DETECT_CTRL);

  // ahb-lite address phase capture, zero wait state
  always @(posedge clock) begin
    if (reset) begin
      ap_addr_reg <= 32'h0000_0000;
      ap_write_reg <= 1'b0;
      ap_valid_reg <= 1'b0;
    end else if (hready) begin
      ap_valid_reg <= addr_phase;
      ap_addr_reg <= haddr;
      ap_write_reg <= hwrite;
    end
  end

  // no wait states: every register answers in one cycle
  always @(posedge clock) begin
    if (reset) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  // no error response; unmapped writes are simply dropped
  always @(posedge clock) begin
    if (reset) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // read data prepared at address phase so it stands in the data phase
  always @(posedge clock) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      if (is_addr(haddr, `ADDR_POWER_CONTROL)) begin
        hrdata <= 32'h0000_0000; // R14
      end else if (is_addr(haddr, `ADDR_POWER_STATUS)) begin
        hrdata <= {30'h0, state_reg};
      end else if (is_addr(haddr, `ADDR_WAKE_ENABLE)) begin
        hrdata <= {24'h0, wake_enable_reg};
      end else if (is_addr(haddr, `ADDR_WATCHDOG_CTRL)) begin
        hrdata <= {watchdog_counter[15:0], 14'h0, watchdog_lock_reg,
                   watchdog_enable_reg};
      end else if (is_addr(haddr, `ADDR_CLOCK_DETECT_CTRL)) begin
        hrdata <= {31'h0, clock_detect_enable_reg};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // wake enable mask
  always @(posedge clock) begin
    if (reset) begin
      wake_enable_reg <= 8'h00;
    end else if (wr_wake) begin
      wake_enable_reg <= hwdata[7:0];
    end
  end

  // enable bit frozen once software sets the sticky lock
  always @(posedge clock) begin
    if (reset) begin
      watchdog_enable_reg <= 1'b1;
    end else if (wr_watchdog && !watchdog_lock_reg) begin
      watchdog_enable_reg <= hwdata[0]; // R9
    end
  end

  // lock only clears on reset
  always @(posedge clock) begin
    if (reset) begin
      watchdog_lock_reg <= 1'b0;
    end else if (wr_watchdog) begin
      watchdog_lock_reg <= watchdog_lock_reg | hwdata[1];
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      watchdog_reload_reg <= `WATCHDOG_RESET_VALUE;
    end else if (wr_watchdog) begin
      watchdog_reload_reg <= hwdata[31:16];
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      clock_detect_enable_reg <= 1'b1;
    end else if (wr_detect) begin
      clock_detect_enable_reg <= hwdata[0]; // R12
    end
  end

  // power state machine
  always @* begin
    state_next = state_reg;
    case (state_reg)
      st_run: begin
        if (set_sleep | set_halt) begin
          state_next = st_pend_sleep; // R1
        end
      end
      st_pend_sleep: begin
        if (instr_complete) begin
          if (pend_deep_reg) begin
            state_next = st_halt; // R10 R15
          end else begin
            state_next = st_sleep; // R4
          end
        end
      end
      st_sleep: begin
        if (wake_now) begin
          state_next = st_run; // R6
        end
      end
      default: begin
        state_next = st_halt; // R11 R13
      end
    endcase
  end

  always @(posedge clock) begin
    if (reset) begin
      state_reg <= st_run;
    end else begin
      state_reg <= state_next;
    end
  end

  // remembers which select bit the write carried until entry
  always @(posedge clock) begin
    if (reset) begin
      pend_deep_reg <= 1'b0;
    end else if (state_reg == st_run) begin
      pend_deep_reg <= set_halt; // R15
    end
  end

  // watchdog keeps counting in light sleep, held at its reload value in deep halt
  always @(posedge clock) begin
    if (reset) begin
      watchdog_counter <= `WATCHDOG_RESET_VALUE;
    end else if (!watchdog_enable_reg || is_deep(state_reg)) begin
      watchdog_counter <= watchdog_reload_reg;
    end else if (watchdog_counter == 16'h0000) begin
      watchdog_counter <= watchdog_reload_reg;
    end else begin
      watchdog_counter <= watchdog_counter - 16'h0001;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      watchdog_fire_reg <= 1'b0;
    end else begin
      watchdog_fire_reg <= watchdog_enable_reg && !is_deep(state_reg) &&
                           (watchdog_counter == 16'h0000); // R9
    end
  end

  // clock detector, the only timer alive in deep halt
  always @(posedge clock) begin
    if (reset) begin
      clock_detect_count_reg <= clock_detect_init;
    end else if (!clock_detect_enable_reg || ext_clock_present) begin
      clock_detect_count_reg <= clock_detect_init;
    end else if (clock_detect_count_reg == 16'h0000) begin
      clock_detect_count_reg <= clock_detect_init;
    end else begin
      clock_detect_count_reg <= clock_detect_count_reg - 16'h0001;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      clock_detect_fire_reg <= 1'b0;
    end else begin
      clock_detect_fire_reg <= clock_detect_enable_reg &&
                               !ext_clock_present &&
                               (clock_detect_count_reg == 16'h0000); // R12
    end
  end

  // outputs straight from flops; core state is untouched while halted
  always @(posedge clock) begin
    if (reset) begin
      core_halt_reg <= 1'b0;
    end else begin
      core_halt_reg <= (state_next == st_sleep) |
                       is_deep(state_next); // R2 R5
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      periph_clock_enable_reg <= 1'b1;
    end else begin
      periph_clock_enable_reg <= !is_deep(state_next); // R3
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      int_osc_enable_reg <= 1'b1;
    end else begin
      int_osc_enable_reg <= !is_deep(state_next); // R3 R13
    end
  end

  // internal reset request; the system loops it back onto reset
  always @(posedge clock) begin
    if (reset) begin
      system_reset_reg <= 1'b0;
    end else begin
      system_reset_reg <= watchdog_fire_reg |
                          clock_detect_fire_reg; // R8 R11
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      reset_vector_reg <= `RESUME_VECTOR;
    end else begin
      reset_vector_reg <= `RESUME_VECTOR; // R8
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      wake_irq_pulse_reg <= 1'b0;
    end else begin
      wake_irq_pulse_reg <= (state_reg == st_sleep) & wake_now; // R7
    end
  end

endmodule

// file: verification/core_power_mode_control_monitor.sv
// assertion checker for the power mode controller ports
`timescale 1ns/100ps
module core_power_monitor (
  input logic clock,
  input logic reset,
  input logic instr_complete,
  input logic [7:0] irq_request,
  input logic core_halt_reg,
  input logic periph_clock_enable_reg,
  input logic int_osc_enable_reg,
  input logic system_reset_reg,
  input logic [15:0] reset_vector_reg,
  input logic wake_irq_pulse_reg
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_osc_needs_halt: assert property (
    !int_osc_enable_reg |-> core_halt_reg && !periph_clock_enable_reg)
    else $error("oscillator off outside deep halt");
  a_sleep_clocks_run: assert property (
    core_halt_reg && int_osc_enable_reg |-> periph_clock_enable_reg)
    else $error("clocks stopped in light sleep");
  a_halt_after_instr: assert property (
    $rose(core_halt_reg) |-> $past(instr_complete))
    else $error("halt before instruction end");
  a_wake_ends_halt: assert property (
    wake_irq_pulse_reg |-> !core_halt_reg ##1 !wake_irq_pulse_reg)
    else $error("wake pulse wrong");
  a_wake_needs_irq: assert property (
    $rose(wake_irq_pulse_reg) |-> $past(irq_request) != 8'h00)
    else $error("wake without request");
  a_deep_holds: assert property (
    !int_osc_enable_reg && !system_reset_reg |=> !int_osc_enable_reg)
    else $error("deep halt left without reset");
  a_no_irq_wake: assert property (
    !int_osc_enable_reg |-> !wake_irq_pulse_reg)
    else $error("interrupt woke deep halt");
  a_vector_zero: assert property (
    reset_vector_reg == 16'h0000)
    else $error("restart vector not zero");
  a_reset_pulse: assert property (
    system_reset_reg |=> !system_reset_reg)
    else $error("internal reset longer than one cycle");
endmodule
bind core_power_mode_control core_power_monitor i_mon (.clock, .reset,
  .instr_complete, .irq_request, .core_halt_reg, .periph_clock_enable_reg,
  .int_osc_enable_reg, .system_reset_reg, .reset_vector_reg,
  .wake_irq_pulse_reg);

// file: verification/testbench.sv
// self-checking bench for the core power mode controller
`timescale 1ns/100ps
`include "core_power_map.vh"
module testbench;
  logic clock = 0, reset = 1, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  logic [1:0] htrans = 0;
  logic instr_complete = 0, ext_clock_present = 1;
  logic [7:0] irq_request = 0;
  wire [31:0] hrdata;
  wire [15:0] vec;
  wire hreadyout, hresp, halt, periph, osc, sysrst, wake;
  int err_total = 0, cmp_count = 0, b;
  core_power_mode_control i_dut (.clock, .reset, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .instr_complete, .irq_request, .ext_clock_present,
    .core_halt_reg(halt), .periph_clock_enable_reg(periph),
    .int_osc_enable_reg(osc), .system_reset_reg(sysrst),
    .reset_vector_reg(vec), .wake_irq_pulse_reg(wake));
  initial forever #10 clock = ~clock;
  task automatic results();
    $display("errors %0d checks %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 0, hresp);
  endtask
  function automatic logic sig(int s);
    return s == 0 ? halt : s == 1 ? wake : sysrst;
  endfunction
  // bounded wait on halt, wake pulse or internal reset
  task automatic wait_for(int s, int lim);
    for (b = 0; b < lim && sig(s) !== 1'b1; b++) tick(1);
    chk("awaited output", 1, sig(s));
  endtask
  // entry must wait for the writing instruction to finish
  task automatic enter(logic [31:0] bits);
    bus(1, `ADDR_POWER_CONTROL, bits);
    tick(3);
    chk("halt early", 0, halt);
    instr_complete <= 1;
    wait_for(0, 20);
    instr_complete <= 0;
  endtask
  task automatic pulse_reset();
    reset <= 1;
    tick(2);
    reset <= 0;
    tick(1);
    chk("after reset", 19'h30000, {halt, periph, osc, vec});
  endtask
  initial begin
    b = $urandom(91265);
    tick(12);
    reset <= 0;
    bus(1, `ADDR_WATCHDOG_CTRL, 0);
    bus(1, `ADDR_WAKE_ENABLE, 32'h0f);
    bus(0, 32'h40 + 4 * ($urandom % 16), 0);
    chk("unmapped", 0, rd);
    enter(1);
    chk("sleep clocks", 3, {periph, osc});
    bus(0, `ADDR_POWER_CONTROL, 0);
    chk("select read", 0, rd);
    bus(0, `ADDR_POWER_STATUS, 0);
    chk("state", 2, rd);
    irq_request <= 8'h10 << ($urandom % 4);
    tick(10);
    chk("masked irq", 1, halt);
    irq_request <= 8'h01 << ($urandom % 4);
    wait_for(1, 10);
    chk("resumed", 0, halt);
    irq_request <= 0;
    enter(3);
    chk("deep", 3'b100, {halt, periph, osc});
    irq_request <= 8'hff;
    tick(20);
    chk("deep stays", 1, halt);
    irq_request <= 0;
    pulse_reset();
    bus(1, `ADDR_WATCHDOG_CTRL, 32'h0010_0000);
    bus(1, `ADDR_WATCHDOG_CTRL, 32'h0010_0001);
    enter(1);
    wait_for(2, 3000);
    pulse_reset();
    enter(2);
    ext_clock_present <= 0;
    wait_for(2, 6000);
    ext_clock_present <= 1;
    results();
  end
  initial begin
    #1000000;
    err_total++;
    results();
  end
endmodule
